// >>> uart_irq_pkg.sv
// Constants, types and register layout of the serial port interrupt and wake-up logic.
`default_nettype none
package uart_irq_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NUM_SRC = 6;
  localparam int unsigned STARTUP_CYCLES_DEF = 16;

  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_INT_CTL = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h2;

  localparam logic [DATA_W-1:0] CONTROL_RST = 8'h00;
  localparam logic [DATA_W-1:0] INT_CTL_RST = 8'h00;

  localparam int unsigned SRC_TXE = 0;
  localparam int unsigned SRC_TXI = 1;
  localparam int unsigned SRC_RX = 2;
  localparam int unsigned SRC_OVR = 3;
  localparam int unsigned SRC_ADDR = 4;
  localparam int unsigned SRC_WAKE = 5;

  typedef struct packed {
    logic port_enable;
    logic receiver_enable;
    logic nine_bit_select;
    logic parity_enable;
    logic pin_wake_enable;
    logic address_detect_enable;
    logic rx_interrupt_enable;
    logic tx_empty_enable;
  } control_s;

  typedef struct packed {
    logic [3:0] spare;
    logic       tx_idle_enable;
    logic       port_interrupt_enable;
    logic       multifunction_group_enable;
    logic       global_interrupt_enable;
  } int_ctl_s;

  typedef struct packed {
    logic tx_empty;
    logic tx_idle;
    logic rx_available_flag;
    logic rx_trigger;
    logic overrun_flag;
  } core_flags_s;

  typedef enum logic [2:0] {
    PS_RUN   = 3'b001,
    PS_OFF   = 3'b010,
    PS_START = 3'b100
  } power_state_e;
endpackage
`default_nettype wire

// >>> uart_interrupt_wakeup_logic.sv
// Interrupt request, address qualification and wake-up logic of a serial port.
`timescale 1ns/100ps
`default_nettype none
module uart_interrupt_wakeup_logic
  import uart_irq_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output var  logic [DATA_W-1:0] reg_rdata,
  // Serial core
  input  wire core_flags_s       core_flags,
  input  wire logic              rx_word_strobe,
  input  wire logic [1:0]        rx_top_bits,
  output var  logic              core_run,
  output var  logic              rx_run,
  output var  logic              rx_ignore,
  // Power manager and processor
  input  wire logic              module_clock_on,
  input  wire logic              cpu_sleep,
  input  wire logic              stack_full,
  output var  logic              wake_up,
  output var  logic              irq_b,
  output var  logic              vector_request,
  // Pin
  input  wire logic              receive_pin
);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  control_s          control;
  control_s          next_control;
  int_ctl_s          int_ctl;
  int_ctl_s          next_int_ctl;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] status_word;

  power_state_e      state;
  power_state_e      next_state;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  next_count;
  logic              wake_pending;
  logic              next_pending;
  logic              next_wake_up;
  logic              wake_qual;

  logic              pin_meta;
  logic              pin_sync;
  logic              pin_last;
  logic              pin_fall;

  logic              top_bit;
  logic              next_top;
  logic [NUM_SRC-1:0] cond;
  logic [NUM_SRC-1:0] cond_q;
  logic [NUM_SRC-1:0] new_src;
  logic              run;
  logic              aden;
  logic              rie;
  logic              vec_ok;

  assign status_word = {1'b0, rx_ignore, wake_pending, core_flags};

  // Status has no write path, so its core flags clear only inside the core and the wake and ignore flags at start-up end.
  always_comb begin
    next_control = control;
    next_int_ctl = int_ctl;
    next_rdata = '0;
    if (reg_we) begin
      case (reg_addr)
        OFS_CONTROL: next_control = control_s'(reg_wdata);
        OFS_INT_CTL: begin
          next_int_ctl = int_ctl_s'(reg_wdata);
          next_int_ctl.spare = '0;
        end
        default: ;
      endcase
    end
    if (reg_re) begin
      case (reg_addr)
        OFS_CONTROL: next_rdata = control;
        OFS_INT_CTL: next_rdata = int_ctl;
        OFS_STATUS:  next_rdata = status_word;
        default:     next_rdata = '0;
      endcase
    end
  end

  // Registers change only on a write; sleep has no path into them.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      control <= control_s'(CONTROL_RST);
      int_ctl <= int_ctl_s'(INT_CTL_RST);
      reg_rdata <= '0;
    end else begin
      control <= next_control;
      int_ctl <= next_int_ctl;
      reg_rdata <= next_rdata;
    end
  end

  a_regs_hold_sleep: assert property (cpu_sleep && !reg_we |=>
    $stable(control) && $stable(int_ctl))
    else $error("registers changed in sleep without a write");

  // The pin is asynchronous; only the synchronised copy is edge-checked.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_last <= 1'b1;
    end else begin
      pin_meta <= receive_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign pin_fall = pin_last & ~pin_sync;
  assign wake_qual = control.pin_wake_enable & control.port_enable
                   & control.receiver_enable & control.rx_interrupt_enable;

  // The start-up count runs after every clock return, woken or not.
  always_comb begin
    next_state = state;
    next_count = count;
    next_pending = wake_pending;
    next_wake_up = 1'b0;
    case (state)
      PS_RUN: begin
        if (!module_clock_on) begin
          next_state = PS_OFF;
        end
      end
      PS_OFF: begin
        if (pin_fall && wake_qual) begin
          next_wake_up = 1'b1;
          next_pending = 1'b1;
        end
        if (module_clock_on) begin
          next_state = PS_START;
          next_count = CNT_W'(STARTUP_CYCLES - 1);
        end
      end
      PS_START: begin
        if (count == '0) begin
          next_state = PS_RUN;
          next_pending = 1'b0;
        end else begin
          next_count = count - CNT_W'(1);
        end
      end
      default: begin
        next_state = PS_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= PS_RUN;
      count <= '0;
      wake_pending <= 1'b0;
      wake_up <= 1'b0;
      rx_ignore <= 1'b0;
      core_run <= 1'b0;
      rx_run <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      wake_pending <= next_pending;
      wake_up <= next_wake_up;
      rx_ignore <= (next_state == PS_START);
      core_run <= module_clock_on;
      rx_run <= module_clock_on & ~cpu_sleep;
    end
  end

  sequence s_clock_back;
    state == PS_OFF && module_clock_on;
  endsequence

  a_startup_ignore: assert property (s_clock_back |=> rx_ignore)
    else $error("pin data not ignored at clock start-up");
  a_clock_pause: assert property (!module_clock_on |=> !core_run && !rx_run)
    else $error("port kept running with clock off");
  a_sleep_pause: assert property (cpu_sleep |=> !rx_run)
    else $error("reception ran during sleep");
  a_wake_fires: assert property (state == PS_OFF && pin_fall && wake_qual |=> wake_up)
    else $error("qualified pin fall gave no wake");
  a_wake_cause: assert property (wake_up |->
    $past(state) == PS_OFF && $past(pin_fall) && $past(wake_qual))
    else $error("wake without qualified pin fall");
  a_run_no_wake: assert property (state == PS_RUN |=> !wake_up)
    else $error("wake raised while clock on");

  // Top received bit is kept so a level trigger can still be qualified.
  always_comb begin
    next_top = top_bit;
    if (rx_word_strobe) begin
      next_top = control.nine_bit_select ? rx_top_bits[1] : rx_top_bits[0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      top_bit <= 1'b0;
    end else begin
      top_bit <= next_top;
    end
  end

  a_top_bit_select: assert property (rx_word_strobe |=>
    top_bit == ($past(control.nine_bit_select) ? $past(rx_top_bits[1]) : $past(rx_top_bits[0])))
    else $error("wrong bit kept for address check");

  // Transfer sources are masked while halted; only wake acts then.
  assign run = (state == PS_RUN);
  assign aden = control.address_detect_enable;
  assign rie = control.rx_interrupt_enable;
  assign vec_ok = int_ctl.global_interrupt_enable & int_ctl.port_interrupt_enable;

  always_comb begin
    cond = '0;
    cond[SRC_TXE] = run & core_flags.tx_empty & control.tx_empty_enable;
    cond[SRC_TXI] = run & core_flags.tx_idle & int_ctl.tx_idle_enable;
    cond[SRC_RX] = run & rie & core_flags.rx_trigger & (~aden | top_bit);
    cond[SRC_OVR] = run & rie & core_flags.overrun_flag;
    cond[SRC_ADDR] = run & aden & rx_word_strobe & next_top;
    cond[SRC_WAKE] = (state == PS_START) & (count == '0) & wake_pending & vec_ok;
  end

  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_edge
      assign new_src[i] = cond[i] & ~cond_q[i];
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cond_q <= '0;
      irq_b <= 1'b1;
      vector_request <= 1'b0;
    end else begin
      cond_q <= cond;
      irq_b <= ~(|new_src);
      vector_request <= (|new_src) & vec_ok & int_ctl.multifunction_group_enable
                        & ~stack_full;
    end
  end

  // The pulse stays visible even when vectoring is masked off, except a wake, whose source needs vec_ok.
  a_irq_cause: assert property (!irq_b |-> $past(new_src) != '0)
    else $error("request pulse without new source");
  a_irq_new: assert property ((|new_src) |=> !irq_b)
    else $error("new source gave no request pulse");
  a_vector_gate: assert property (vector_request |->
    !irq_b && $past(vec_ok) && !$past(stack_full))
    else $error("vector without all enables");
  a_vector_group: assert property (vector_request |->
    $past(int_ctl.multifunction_group_enable))
    else $error("vector without group enable");
  a_addr_block: assert property (run && rie && aden && !top_bit |-> !cond[SRC_RX])
    else $error("data word raised rx interrupt in address mode");
  a_no_addr_mode: assert property (run && rie && !aden && core_flags.rx_trigger |->
    cond[SRC_RX])
    else $error("trigger missed with address mode off");
  a_wake_waits: assert property (state != PS_RUN && count != '0 |-> !cond[SRC_WAKE])
    else $error("wake interrupt before start-up end");
  // While halted, only the wake source may raise a request.
  a_halt_mask: assert property (state != PS_RUN |-> cond[SRC_ADDR:SRC_TXE] == '0)
    else $error("transfer source raised while halted");

endmodule
`default_nettype wire

// >>> power_model.sv
// Power manager model that stops the port clock and restarts it after a wake-up.
`timescale 1ns/100ps
`default_nettype none
module power_model #(
  parameter int ON_DELAY = 4
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Requests and answer
  input  wire logic sleep_cmd,
  input  wire logic wake_up,
  output var  logic module_clock_on
);
  int cnt;
  // The restart delay stands in for oscillator settling, so start-up is never instant.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      module_clock_on <= 1'b1;
      cnt             <= 0;
    end else if (sleep_cmd) begin
      module_clock_on <= 1'b0;
    end else if (wake_up) begin
      cnt <= ON_DELAY;
    end else if (cnt == 1) begin
      module_clock_on <= 1'b1;
      cnt             <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the serial port interrupt and wake-up logic.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import uart_irq_pkg::*;
  logic              clock, rst_b, reg_we, reg_re, rx_word_strobe, cpu_sleep, stack_full;
  logic              receive_pin, sleep_cmd, core_run, rx_run, rx_ignore, wake_up;
  logic              irq_b, vector_request, module_clock_on, top, exp_v;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, ctl;
  logic [1:0]        rx_top_bits;
  logic [3:0]        ic;
  core_flags_s       core_flags;
  int                err_total, checks_done, seed, irq_n, vec_n, ign_n, wake_n, i0, v0, g0, w0;

  uart_interrupt_wakeup_logic #(.STARTUP_CYCLES(2)) uut (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .core_flags(core_flags),
    .rx_word_strobe(rx_word_strobe), .rx_top_bits(rx_top_bits), .core_run(core_run),
    .rx_run(rx_run), .rx_ignore(rx_ignore), .module_clock_on(module_clock_on),
    .cpu_sleep(cpu_sleep), .stack_full(stack_full), .wake_up(wake_up), .irq_b(irq_b),
    .vector_request(vector_request), .receive_pin(receive_pin));
  power_model pm (.clock(clock), .rst_b(rst_b), .sleep_cmd(sleep_cmd), .wake_up(wake_up),
    .module_clock_on(module_clock_on));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Pulse counters let a check cover a whole window, not one guessed cycle.
  always @(posedge clock) begin
    if (irq_b === 1'b0) irq_n++;
    if (vector_request === 1'b1) vec_n++;
    if (rx_ignore === 1'b1) ign_n++;
    if (wake_up === 1'b1) wake_n++;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask

  task automatic test_done;
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic snap;
    i0 = irq_n;
    v0 = vec_n;
    g0 = ign_n;
    w0 = wake_n;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clock);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1 chk(nm, reg_rdata, e);
    @(posedge clock);
  endtask

  initial begin
    seed = 7;
    rst_b = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    core_flags = '0;
    rx_word_strobe = 1'b0;
    rx_top_bits = 2'h0;
    cpu_sleep = 1'b0;
    stack_full = 1'b0;
    receive_pin = 1'b1;
    sleep_cmd = 1'b0;
    cyc(12);
    rst_b <= 1'b1;
    #1 chk("irq_b", {7'h0, irq_b}, 8'h01);
    rd(OFS_CONTROL, CONTROL_RST, "control");
    wr(OFS_INT_CTL, 8'hff);
    rd(OFS_INT_CTL, 8'h0f, "int_ctl");
    rd(4'hf, 8'h00, "unmapped");
    for (int k = 0; k < 16; k++) begin
      ic = 4'($random(seed));
      wr(OFS_INT_CTL, {4'h0, ic});
      wr(OFS_CONTROL, 8'h01);
      stack_full <= 1'($random(seed));
      snap;
      core_flags.tx_empty <= 1'b1;
      cyc(4);
      exp_v = ic[0] & ic[1] & ic[2] & ~stack_full;
      chk("txe irq", 8'(irq_n - i0), 8'h01);
      chk("vector", 8'(vec_n - v0), {7'h0, exp_v});
      snap;
      core_flags.tx_idle <= 1'b1;
      cyc(4);
      chk("txi irq", 8'(irq_n - i0), {7'h0, ic[3]});
      wr(OFS_STATUS, 8'($random(seed)));
      rd(OFS_STATUS, 8'h18, "status");
      core_flags <= '0;
    end
    wr(OFS_INT_CTL, 8'h07);
    for (int j = 0; j < 8; j++) begin
      ctl = {2'b11, j[1], 2'b00, j[2], 2'b10}; // Parity stays off in address mode
      wr(OFS_CONTROL, ctl);
      snap;
      rx_word_strobe <= 1'b1;
      rx_top_bits <= j[0] ? 2'b10 : 2'b01;
      cyc(1);
      rx_word_strobe <= 1'b0;
      core_flags.rx_trigger <= 1'b1;
      cyc(4);
      top = j[1] ? rx_top_bits[1] : rx_top_bits[0];
      chk("rx irq", 8'(irq_n - i0), !j[2] ? 8'h01 : (top ? 8'h02 : 8'h00));
      core_flags.rx_trigger <= 1'b0;
      cyc(1);
    end
    snap;
    core_flags.overrun_flag <= 1'b1;
    cyc(4);
    chk("ovr irq", 8'(irq_n - i0), 8'h01);
    core_flags.overrun_flag <= 1'b0;
    cpu_sleep <= 1'b1;
    cyc(3);
    chk("rx_run", {6'h0, rx_run, core_run}, 8'h01);
    cpu_sleep <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      wr(OFS_INT_CTL, k ? 8'h07 : 8'h02);
      wr(OFS_CONTROL, 8'hca);
      sleep_cmd <= 1'b1; // No transfer is running when sleep is asked
      cyc(1);
      sleep_cmd <= 1'b0;
      cyc(3);
      chk("core_run", {7'h0, core_run}, 8'h00);
      rd(OFS_CONTROL, 8'hca, "control");
      snap;
      receive_pin <= 1'b0;
      for (int n = 0; n < 50 && wake_n == w0; n++) cyc(1);
      if (wake_n == w0) begin
        err_total++;
        test_done;
      end
      cyc(30);
      receive_pin <= 1'b1;
      chk("wake", 8'(wake_n - w0), 8'h01);
      chk("wake irq", 8'(irq_n - i0), k ? 8'h01 : 8'h00);
      chk("ignore", 8'(ign_n - g0), 8'h02);
      cyc(4);
      snap;
      receive_pin <= 1'b0;
      cyc(8);
      receive_pin <= 1'b1;
      chk("run fall", 8'(wake_n - w0), 8'h00);
    end
    cyc(2);
    test_done;
  end
endmodule
`default_nettype wire
